// file: src/dacfe_top.sv
// Top of the DAC digital front end: capture, invert, decode, delay
`timescale 1ns/1ns
`default_nettype none
module dacfe_top
	import dacfe_pkg::*;
(
	input  wire logic        MCLK,               // Sample clock, true line
	input  wire logic        RESET_N,            // Synchronous reset, active low
	input  wire logic [9:0]  SAMPLE_BITS,        // Sample word, bit 9 is first input
	input  wire logic        SAMPLE_VALID,       // Source offers a word
	output logic             SAMPLE_READY,       // Buffer can take a word
	input  wire logic        INVERT,             // Quadrature invert pin
	output logic [14:0]      THERMO_SWITCH,      // Upper segment switches
	output logic [5:0]       BINARY_SWITCH,      // Delayed lower switches
	output logic [9:0]       CURRENT_OUT_TRUE,   // Code steered to true output
	output logic [9:0]       CURRENT_OUT_COMPLEMENT, // Code on complement output
	output logic             OUT_STROBE          // New code on switches
);
	//==========================================================
	// Input buffering
	//==========================================================
	logic [9:0] buf_data;     // Word leaving buffer
	logic       buf_valid;    // Buffer not empty
	logic       fifo_ready;   // Buffer not full
	logic       inv_level;    // Synchronised invert level

	// Buffer of sample words; the register drains one word per edge
	dacfe_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.in_data   (SAMPLE_BITS),
		.in_valid  (SAMPLE_VALID),
		.in_ready  (fifo_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (1'b1)
	);
	assign SAMPLE_READY = fifo_ready;

	// Invert pin arrives from outside, so it is synchronised
	dacfe_sync u_sync (
		.clk   (MCLK),
		.rst_n (RESET_N),
		.din   (INVERT),
		.dout  (inv_level)
	);

	//==========================================================
	// Inversion and input register
	//==========================================================
	logic [9:0] next_word;    // Word after inversion
	logic [9:0] word;         // Registered word
	logic       word_new;     // Word captured this edge

	// Invert nine lower bits when invert high and MSB low
	always_comb begin
		next_word = buf_data;
		if (inv_level && !buf_data[9]) begin
			next_word = {buf_data[9], buf_data[8:0] ^ LOW_MASK};
		end
	end

	// Register captures full word on rising edges where the buffer offers one, holds otherwise
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			word     <= RESET_CODE;
			word_new <= 1'b0;
		end else begin
			word_new <= buf_valid;
			if (buf_valid) begin
				word <= next_word;
			end
		end
	end

	//==========================================================
	// Decoder and equalising delay
	//==========================================================
	logic [5:0] low_dly;      // Lower bits delayed one stage
	logic       strobe_dly;   // Strobe aligned with decoder

	// Thermometer decode of upper bits
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			THERMO_SWITCH <= 15'h0000;
		end else begin
			THERMO_SWITCH <= dacfe_thermo(word[9:6]);
		end
	end

	// Lower bits and clock marker take equal delay to decoder
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			low_dly    <= 6'h00;
			strobe_dly <= 1'b0;
		end else begin
			low_dly    <= word[5:0];
			strobe_dly <= word_new;
		end
	end
	assign BINARY_SWITCH = low_dly;
	assign OUT_STROBE    = strobe_dly;

	//==========================================================
	// Output current steering
	//==========================================================
	// Straight binary magnitudes on true and complement
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			CURRENT_OUT_TRUE       <= RESET_CODE;
			CURRENT_OUT_COMPLEMENT <= FULL_SCALE;
		end else begin
			CURRENT_OUT_TRUE       <= word;
			CURRENT_OUT_COMPLEMENT <= dacfe_compl(word);
		end
	end

	//==========================================================
	// Assertions
	//==========================================================
	property p_capture;
		@(posedge MCLK) disable iff (!RESET_N)
		buf_valid |=> word == $past(next_word);
	endproperty
	a_capture: assert property (p_capture) else $error("word not captured");

	property p_hold;
		@(posedge MCLK) disable iff (!RESET_N)
		!buf_valid |=> $stable(word);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed without load");

	property p_pass;
		@(posedge MCLK) disable iff (!RESET_N)
		!inv_level |-> next_word == buf_data;
	endproperty
	a_pass: assert property (p_pass) else $error("bits altered while not inverting");

	property p_invert;
		@(posedge MCLK) disable iff (!RESET_N)
		(inv_level && !buf_data[9]) |-> next_word == {1'b0, ~buf_data[8:0]};
	endproperty
	a_invert: assert property (p_invert) else $error("lower bits not inverted");

	property p_msb_kept;
		@(posedge MCLK) disable iff (!RESET_N)
		next_word[9] == buf_data[9];
	endproperty
	a_msb_kept: assert property (p_msb_kept) else $error("msb inverted");

	property p_thermo;
		@(posedge MCLK) disable iff (!RESET_N)
		##1 $countones(THERMO_SWITCH) == int'($past(word[9:6]));
	endproperty
	a_thermo: assert property (p_thermo) else $error("thermometer count wrong");

	property p_align;
		@(posedge MCLK) disable iff (!RESET_N)
		##1 BINARY_SWITCH == $past(word[5:0]) && OUT_STROBE == $past(word_new);
	endproperty
	a_align: assert property (p_align) else $error("lower bits misaligned");

	property p_sum;
		@(posedge MCLK) disable iff (!RESET_N)
		(11'(CURRENT_OUT_TRUE) + 11'(CURRENT_OUT_COMPLEMENT)) == 11'(FULL_SCALE);
	endproperty
	a_sum: assert property (p_sum) else $error("output sum not full scale");

	property p_binary;
		@(posedge MCLK) disable iff (!RESET_N)
		##1 CURRENT_OUT_TRUE == $past(word);
	endproperty
	a_binary: assert property (p_binary) else $error("true output not binary code");

	c_invert: cover property (@(posedge MCLK) disable iff (!RESET_N)
		inv_level && !buf_data[9] && buf_valid);
	c_full: cover property (@(posedge MCLK) disable iff (!RESET_N)
		CURRENT_OUT_TRUE == FULL_SCALE);
	c_stall: cover property (@(posedge MCLK) disable iff (!RESET_N)
		!fifo_ready);
endmodule : dacfe_top
`default_nettype wire

// file: src/dacfe_pkg.sv
// Package with constants and functions of the DAC front end
//==========================================================
// Contract
// - Register whole sample word every rising edge; the register loads only on edges where the buffer offers a word
// - Single-ended variant uses true clock only
// - Ten bits, first input is MSB
// - Invert control low passes bits unchanged
// - Invert high, MSB low inverts nine LSBs
// - Four MSBs decode to fifteen thermometer lines
// - Six LSBs delayed to match decoder path
// - Straight binary, all ones is full scale
// - True plus complement equals full scale
//==========================================================
package dacfe_pkg;
	localparam int    SAMPLE_W     = 10;           // Sample word width
	localparam int    THERMO_BITS  = 4;            // Upper bits decoded
	localparam int    BINARY_BITS  = 6;            // Lower bits passed binary
	localparam int    THERMO_LINES = 15;           // Thermometer lines
	localparam int    FIFO_DEPTH   = 32;           // Buffer depth in words
	localparam int    SYNC_STAGES  = 3;            // Pin synchroniser stages
	localparam logic [9:0] FULL_SCALE  = 10'h3FF;  // Full-scale code
	localparam logic [9:0] RESET_CODE  = 10'h000;  // Code after reset
	localparam logic [8:0] LOW_MASK    = 9'h1FF;   // Nine inverted bits

	// Thermometer decode of the four upper bits
	function automatic logic [14:0] dacfe_thermo(input logic [3:0] v);
		logic [14:0] t;
		t = 15'h0000;
		for (int i = 0; i < THERMO_LINES; i++) begin
			t[i] = (v > i[3:0]);
		end
		return t;
	endfunction : dacfe_thermo

	// Complementary magnitude, steps below full scale
	function automatic logic [9:0] dacfe_compl(input logic [9:0] v);
		return FULL_SCALE - v;
	endfunction : dacfe_compl
endpackage : dacfe_pkg

// file: src/dacfe_sync.sv
// Three-stage synchroniser with agreement check for one pin
`timescale 1ns/1ns
`default_nettype none
module dacfe_sync
	import dacfe_pkg::*;
(
	input  wire logic clk,     // Clock
	input  wire logic rst_n,   // Synchronous reset, active low
	input  wire logic din,     // Asynchronous pin
	output var  logic dout     // Filtered level
);
	logic s1;                  // First stage, read by s2 only
	logic s2;                  // Second stage
	logic s3;                  // Third stage

	// Shift chain and agreement filter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule : dacfe_sync
`default_nettype wire

// file: src/dacfe_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dacfe_fifo
	import dacfe_pkg::*;
#(
	parameter int WIDTH = SAMPLE_W,   // Word width
	parameter int DEPTH = FIFO_DEPTH  // Word count
)(
	input  wire logic             clk,       // Clock
	input  wire logic             rst_n,     // Synchronous reset, active low
	input  wire logic [WIDTH-1:0] in_data,   // Write word
	input  wire logic             in_valid,  // Write request
	output var  logic             in_ready,  // Not full
	output var  logic [WIDTH-1:0] out_data,  // Read word, registered
	output var  logic             out_valid, // Not empty
	input  wire logic             out_ready  // Drain accepts
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];           // Storage
	logic [AW-1:0]    wp;                    // Write pointer
	logic [AW-1:0]    rp;                    // Read pointer
	logic [AW:0]      cnt;                   // Fill level
	logic             wr;                    // Write happens
	logic             rd;                    // Read happens
	logic [AW:0]      next_cnt;              // Fill level after this edge
	logic [AW-1:0]    next_rp;               // Read pointer after this edge

	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;

	// Fill level and read pointer as they will stand after this edge
	always_comb begin
		next_cnt = cnt + (AW+1)'(wr) - (AW+1)'(rd);
		next_rp  = rp;
		if (rd) begin
			next_rp = (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
		end
	end

	// Storage write
	always_ff @(posedge clk) begin
		if (wr) begin
			mem[wp] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (wr) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
			rp  <= next_rp;
			cnt <= next_cnt;
		end
	end

	// Registered flags and read word (first-word fall through one cycle late)
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			in_ready  <= (next_cnt != (AW+1)'(DEPTH));
			// Word at the next read slot written this edge is not readable yet
			out_valid <= (next_cnt != '0) && !(wr && (next_rp == wp));
			out_data  <= mem[next_rp];
		end
	end
endmodule : dacfe_fifo
`default_nettype wire

// file: testbench/dacfe_src.sv
// Sample source model feeding the front end with valid and ready
`timescale 1ns/1ns
`default_nettype none
module dacfe_src (
	input  wire logic       clk,   // Sample clock from the bench
	input  wire logic       ready, // Front end can take a word
	output var  logic [9:0] bits,  // Offered sample word
	output var  logic       valid  // Offer flag
);
	logic [9:0] q[$];  // Words still to send

	initial begin
		bits  = 10'h155;
		valid = 1'b0;
	end

	// Queue a word for sending
	task automatic push(input logic [9:0] w);
		q.push_back(w);
	endtask : push

	// Hold an offer until taken; idle data toggles as a released bus
	always @(posedge clk) begin
		if (valid && !ready) begin
			valid <= 1'b1;
		end else if (q.size() > 0) begin
			bits  <= q.pop_front();
			valid <= 1'b1;
		end else begin
			bits  <= ~bits;
			valid <= 1'b0;
		end
	end
endmodule : dacfe_src
`default_nettype wire

// file: testbench/dacfe_top_tb.sv
// Testbench of the front end: capture, invert, decode and outputs
`timescale 1ns/1ns
`default_nettype none
module dacfe_top_tb;
	import dacfe_pkg::*;
	logic        MCLK = 1'b0;  // Sample clock
	logic        RESET_N = 1'b0; // Reset, active low
	logic        INVERT = 1'b0;  // Invert pin, always defined
	logic        ready;          // Buffer ready
	logic [14:0] thermo;         // Segment lines
	logic [5:0]  binsw;          // Lower switches
	logic [9:0]  cur_t;          // True output code
	logic [9:0]  cur_c;          // Complement output code
	logic        strobe;         // New code flag
	logic [9:0]  exp_q[$];       // Expected codes
	logic        inv_now = 1'b0; // Invert level in force
	int          n_fail = 0;     // Mismatches
	int          num_checks = 0; // Comparisons
	int          cyc = 0;        // Cycle counter
	logic [9:0]  src_bits;       // Word offered by the source
	logic        src_valid;      // Source offer flag
	logic [9:0]  prev_t;         // True output one edge earlier

	dacfe_src src (
		.clk   (MCLK),
		.ready (ready),
		.bits  (src_bits),
		.valid (src_valid)
	);

	// Clock of 100 ns period
	always #50 MCLK = ~MCLK;

	dacfe_top dut (
		.MCLK(MCLK), .RESET_N(RESET_N), .SAMPLE_BITS(src_bits),
		.SAMPLE_VALID(src_valid), .SAMPLE_READY(ready), .INVERT(INVERT),
		.THERMO_SWITCH(thermo), .BINARY_SWITCH(binsw),
		.CURRENT_OUT_TRUE(cur_t), .CURRENT_OUT_COMPLEMENT(cur_c),
		.OUT_STROBE(strobe)
	);

	// Compare one result
	task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Print the counts and the verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Send a word and note the code expected at the switches
	task automatic send(input logic [9:0] w);
		logic [9:0] e;
		e = (inv_now && !w[9]) ? {1'b0, ~w[8:0]} : w;
		exp_q.push_back(e);
		src.push(w);
	endtask : send

	// Wait until every expected code has appeared
	task automatic drain();
		for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(posedge MCLK);
		chk("pending", 15'h0000, 15'(exp_q.size()));
	endtask : drain

	// Judge each new code, and stability between codes
	always @(posedge MCLK) begin
		logic [9:0]  e;
		logic [15:0] th;
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			wrap_up();
		end else begin
			if (RESET_N && strobe === 1'b1) begin
				e  = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h2AA;
				th = (16'h0001 << e[9:6]) - 16'h0001;
				chk("thermo", {1'b0, th[14:0]}, thermo);
				chk("binary", 15'(e[5:0]), 15'(binsw));
				chk("true", 15'(e), 15'(cur_t));
				chk("compl", 15'(FULL_SCALE - e), 15'(cur_c));
			end else if (RESET_N && cyc > 12) begin
				chk("hold", 15'(prev_t), 15'(cur_t));
			end
			prev_t = cur_t;
		end
	end

	// Reset values of the outputs
	task automatic t_reset();
		chk("rst true", 15'h0000, 15'(cur_t));
		chk("rst compl", 15'h03FF, 15'(cur_c));
		chk("rst strobe", 15'h0000, 15'(strobe));
		chk("rst ready", 15'h0001, 15'(ready));
	endtask : t_reset

	// Back-to-back words, extremes and bit order
	task automatic t_plain();
		send(10'h3FF);
		send(10'h000);
		send(10'h200);
		send(10'h001);
		for (int i = 0; i < 16; i++) send(10'((i << 6) | (63 - i)));
		drain();
	endtask : t_plain

	// Quadrature inversion with the upper bit low and high
	task automatic t_invert();
		INVERT <= 1'b1;
		repeat (10) @(posedge MCLK);
		inv_now = 1'b1;
		send(10'h0F0);
		send(10'h2F0);
		send(10'h1FF);
		drain();
		INVERT <= 1'b0;
		repeat (10) @(posedge MCLK);
		inv_now = 1'b0;
		send(10'h0F0);
		drain();
	endtask : t_invert

	// Main sequence
	initial begin
		repeat (8) @(posedge MCLK);
		RESET_N <= 1'b1;
		repeat (2) @(posedge MCLK);
		t_reset();
		t_plain();
		t_invert();
		wrap_up();
	end
endmodule : dacfe_top_tb
`default_nettype wire
